// [shared/option_bytes_defs.vh]
// Purpose: constants for the option byte configuration loader
// Assumes: byte-wide access at data-memory addresses, one system clock
// Notes: all timing counts are in cycles of the 50 MHz system clock
//
// What this block does
// - external programmer may rewrite every option byte but the reserved one over the debug link.
// - firmware may rewrite bytes; protection and boot size apply only via programmer.
// - protection byte at 0x4800; pattern 0xAA disables readout protection.
// - boot area size at 0x4802; zero means none, one means vectors only.
// - size two protects pages 0-1; larger N write-protects pages 0 to N-1.
// - watchdog byte bit 0 set starts independent watchdog by hardware.
// - independent halt bit set stops that watchdog in halt modes.
// - window hardware bit set starts the window watchdog by hardware.
// - window halt bit set resets on halt entry, clear stops it.
// - oscillator byte bits 1:0 pick fast settle 1, 16, 512, 4096 cycles.
// - oscillator byte bits 3:2 pick slow settle with the same mapping.
// - brownout byte bit 0 enables brownout reset.
// - brownout byte bits 3:1 select the brownout threshold.
// - boot select word and reset vector decide bootloader or reset vector.
`ifndef OPTION_BYTES_DEFS_VH
`define OPTION_BYTES_DEFS_VH

`define ADDR_READOUT_PROTECT 16'h4800
`define ADDR_USER_BOOT_AREA 16'h4802
`define ADDR_RESERVED_OPT 16'h4807
`define ADDR_WATCHDOG_OPT 16'h4808
`define ADDR_OSC_SETTLE 16'h4809
`define ADDR_BROWNOUT_OPT 16'h480A
`define ADDR_BOOT_SEL_FIRST 16'h480B
`define ADDR_BOOT_SEL_SECOND 16'h480C

`define RST_READOUT_PROTECT 8'hAA
`define RST_USER_BOOT_AREA 8'h00
`define RST_WATCHDOG_OPT 8'h00
`define RST_OSC_SETTLE 8'h00
`define RST_BROWNOUT_OPT 8'h00
`define RST_BOOT_SEL 8'h00

`define READOUT_UNLOCK_PATTERN 8'hAA
`define UBA_NONE 8'h00
`define UBA_VECTORS_ONLY 8'h01
`define UBA_TWO_PAGES 8'h02

`define BIT_INDEP_DOG_HW 0
`define BIT_INDEP_DOG_HALT 1
`define BIT_WINDOW_DOG_HW 2
`define BIT_WINDOW_DOG_HALT 3
`define WDOG_USED_MASK 8'h0F
`define OSC_USED_MASK 8'h0F
`define BOR_USED_MASK 8'h0F
`define BIT_BROWNOUT_EN 0
`define FAST_SETTLE_LSB 0
`define SLOW_SETTLE_LSB 2
`define BROWNOUT_THR_LSB 1

`define SETTLE_CYC_0 13'h0001
`define SETTLE_CYC_1 13'h0010
`define SETTLE_CYC_2 13'h0200
`define SETTLE_CYC_3 13'h1000

`endif

// [hdl/option_byte_cell.v]
// Purpose: one nonvolatile option byte with a reset-time configuration latch
// Assumes: write strobes are one cycle and synchronous to i_clk
// Notes: stored value survives i_nrst; the latch samples it at reset release
`timescale 1ns/1ns
module option_byte_cell #(
    parameter [7:0] RESET_VAL = 8'h00,
    parameter [7:0] USED_MASK = 8'hFF
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_por_n,
    input wire i_wr,
    input wire [7:0] i_wdata,
    input wire i_load,
    output reg [7:0] o_stored,
    output reg [7:0] o_active
);
    // stored array is loaded with RESET_VAL only by the power-on reset, not by system reset
    always @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            o_stored <= RESET_VAL;
        end else if (i_wr) begin
            o_stored <= i_wdata & USED_MASK;
        end
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_active <= RESET_VAL;
        end else if (i_load) begin
            o_active <= o_stored;
        end
    end
endmodule

// [hdl/option_byte_config_loader.v]
// Purpose: option byte store, access paths and decoded hardware configuration
// Assumes: programmer and firmware ports are single-cycle byte strobes
// Notes: decoded outputs change only after a reset, never while running
`include "option_bytes_defs.vh"
`timescale 1ns/1ns
module option_byte_config_loader (
    input wire i_clk,
    input wire i_nrst,
    input wire i_por_n,
    input wire i_prog_wr,
    input wire i_prog_rd,
    input wire [15:0] i_prog_addr,
    input wire [7:0] i_prog_wdata,
    output reg [7:0] o_prog_rdata,
    output reg o_prog_ack,
    input wire i_app_wr,
    input wire i_app_rd,
    input wire [15:0] i_app_addr,
    input wire [7:0] i_app_wdata,
    output reg [7:0] o_app_rdata,
    output reg o_app_ack,
    input wire [7:0] i_reset_vector_byte,
    output reg o_readout_protect,
    output reg [7:0] o_user_boot_area,
    output reg o_uba_vectors_only,
    output reg o_uba_read_protect,
    output reg [7:0] o_uba_last_page,
    output reg o_indep_dog_hw_start,
    output reg o_indep_dog_halt_stop,
    output reg o_window_dog_hw_start,
    output reg o_window_dog_halt_reset,
    output reg [12:0] o_fast_osc_settle_cycles,
    output reg [12:0] o_slow_osc_settle_cycles,
    output reg o_brownout_enable,
    output reg [2:0] o_brownout_threshold,
    output reg [15:0] o_boot_select_word,
    output reg o_jump_bootloader,
    output reg o_config_valid
);
    // ************************************************************
    // option byte store
    // ************************************************************
    localparam N = 7;
    wire [7:0] stored [0:N-1];
    wire [7:0] active [0:N-1];
    wire [N-1:2] wr_sel;
    reg load_r;
    reg load_done_r;
    reg [2:0] prog_idx;
    reg prog_hit;
    reg [2:0] app_idx;
    reg app_hit;

    // ************************************************************
    // address decode
    // ************************************************************
    function [3:0] decode;
        input [15:0] a;
        begin
            if (a == `ADDR_READOUT_PROTECT) begin
                decode = 4'h8;
            end else if (a == `ADDR_USER_BOOT_AREA) begin
                decode = 4'h9;
            end else if (a == `ADDR_WATCHDOG_OPT) begin
                decode = 4'hA;
            end else if (a == `ADDR_OSC_SETTLE) begin
                decode = 4'hB;
            end else if (a == `ADDR_BROWNOUT_OPT) begin
                decode = 4'hC;
            end else if (a == `ADDR_BOOT_SEL_FIRST) begin
                decode = 4'hD;
            end else if (a == `ADDR_BOOT_SEL_SECOND) begin
                decode = 4'hE;
            end else begin
                // reserved byte and unmapped addresses: no cell
                decode = 4'h0;
            end
        end
    endfunction

    always @* begin
        {prog_hit, prog_idx} = decode(i_prog_addr);
        {app_hit, app_idx} = decode(i_app_addr);
    end

    // ************************************************************
    // write steering
    // ************************************************************
    // only the freely writable bytes are muxed here; the protection and
    // size cells listen to the programmer port alone
    genvar g;
    generate
        for (g = 2; g < N; g = g + 1) begin : cells
            // programmer has priority when both write the same cycle
            assign wr_sel[g] = (i_prog_wr && prog_hit && prog_idx == g) ||
                               (i_app_wr && app_hit && app_idx == g &&
                                !(i_prog_wr && prog_hit && prog_idx == g));
        end
    endgenerate

    wire [7:0] wdata [2:N-1];
    generate
        for (g = 2; g < N; g = g + 1) begin : wmux
            assign wdata[g] = (i_prog_wr && prog_hit && prog_idx == g) ?
                              i_prog_wdata : i_app_wdata;
        end
    endgenerate

    // ************************************************************
    // firmware shadow copies
    // ************************************************************
    // protection and boot size: firmware writes are stored nowhere that applies,
    // so a shadow keeps the firmware copy readable while the effective cell holds
    reg [7:0] app_shadow_prot_r;
    reg [7:0] app_shadow_uba_r;
    reg prot_app_dirty_r;
    reg uba_app_dirty_r;
    wire app_wr_prot = i_app_wr && app_hit && app_idx == 3'd0;
    wire app_wr_uba = i_app_wr && app_hit && app_idx == 3'd1;
    wire prog_wr_prot = i_prog_wr && prog_hit && prog_idx == 3'd0;
    wire prog_wr_uba = i_prog_wr && prog_hit && prog_idx == 3'd1;

    always @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            app_shadow_prot_r <= 8'h00;
            app_shadow_uba_r <= 8'h00;
            prot_app_dirty_r <= 1'b0;
            uba_app_dirty_r <= 1'b0;
        end else begin
            if (prog_wr_prot) begin
                prot_app_dirty_r <= 1'b0;
            end else if (app_wr_prot) begin
                app_shadow_prot_r <= i_app_wdata;
                prot_app_dirty_r <= 1'b1;
            end
            if (prog_wr_uba) begin
                uba_app_dirty_r <= 1'b0;
            end else if (app_wr_uba) begin
                app_shadow_uba_r <= i_app_wdata;
                uba_app_dirty_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // option byte cells
    // ************************************************************
    option_byte_cell #(.RESET_VAL(`RST_READOUT_PROTECT), .USED_MASK(8'hFF)) u_prot (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_por_n(i_por_n),
        .i_wr(prog_wr_prot), .i_wdata(i_prog_wdata), .i_load(load_r),
        .o_stored(stored[0]), .o_active(active[0]));
    option_byte_cell #(.RESET_VAL(`RST_USER_BOOT_AREA), .USED_MASK(8'hFF)) u_uba (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_por_n(i_por_n),
        .i_wr(prog_wr_uba), .i_wdata(i_prog_wdata), .i_load(load_r),
        .o_stored(stored[1]), .o_active(active[1]));
    option_byte_cell #(.RESET_VAL(`RST_WATCHDOG_OPT), .USED_MASK(`WDOG_USED_MASK)) u_wdg (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_por_n(i_por_n),
        .i_wr(wr_sel[2]), .i_wdata(wdata[2]), .i_load(load_r),
        .o_stored(stored[2]), .o_active(active[2]));
    option_byte_cell #(.RESET_VAL(`RST_OSC_SETTLE), .USED_MASK(`OSC_USED_MASK)) u_osc (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_por_n(i_por_n),
        .i_wr(wr_sel[3]), .i_wdata(wdata[3]), .i_load(load_r),
        .o_stored(stored[3]), .o_active(active[3]));
    option_byte_cell #(.RESET_VAL(`RST_BROWNOUT_OPT), .USED_MASK(`BOR_USED_MASK)) u_bor (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_por_n(i_por_n),
        .i_wr(wr_sel[4]), .i_wdata(wdata[4]), .i_load(load_r),
        .o_stored(stored[4]), .o_active(active[4]));
    option_byte_cell #(.RESET_VAL(`RST_BOOT_SEL), .USED_MASK(8'hFF)) u_bl0 (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_por_n(i_por_n),
        .i_wr(wr_sel[5]), .i_wdata(wdata[5]), .i_load(load_r),
        .o_stored(stored[5]), .o_active(active[5]));
    option_byte_cell #(.RESET_VAL(`RST_BOOT_SEL), .USED_MASK(8'hFF)) u_bl1 (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_por_n(i_por_n),
        .i_wr(wr_sel[6]), .i_wdata(wdata[6]), .i_load(load_r),
        .o_stored(stored[6]), .o_active(active[6]));

    // ************************************************************
    // read paths
    // ************************************************************
    // reads return the stored array or a firmware shadow, not the latched copy, so a programmer
    // can verify a write before the next reset applies it
    reg [7:0] prog_rd_nxt;
    reg [7:0] app_rd_nxt;
    always @* begin
        prog_rd_nxt = 8'h00;
        app_rd_nxt = 8'h00;
        if (prog_hit) begin
            prog_rd_nxt = stored[prog_idx];
        end
        if (app_hit) begin
            if (app_idx == 3'd0 && prot_app_dirty_r) begin
                app_rd_nxt = app_shadow_prot_r;
            end else if (app_idx == 3'd1 && uba_app_dirty_r) begin
                app_rd_nxt = app_shadow_uba_r;
            end else begin
                app_rd_nxt = stored[app_idx];
            end
        end
    end

    // ************************************************************
    // acknowledge and read data registers
    // ************************************************************
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prog_rdata <= 8'h00;
            o_prog_ack <= 1'b0;
            o_app_rdata <= 8'h00;
            o_app_ack <= 1'b0;
        end else begin
            o_prog_ack <= i_prog_wr | i_prog_rd;
            o_app_ack <= i_app_wr | i_app_rd;
            if (i_prog_rd) begin
                o_prog_rdata <= prog_rd_nxt;
            end
            if (i_app_rd) begin
                o_app_rdata <= app_rd_nxt;
            end
        end
    end

    // ************************************************************
    // load at reset release and decode
    // ************************************************************
    // load pulses one cycle after release so the latches see a settled store
    // every i_nrst re-arms it, so bytes written now apply from the next reset
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            load_r <= 1'b0;
            load_done_r <= 1'b0;
        end else begin
            load_r <= !load_done_r;
            load_done_r <= 1'b1;
        end
    end

    // ************************************************************
    // settle count table
    // ************************************************************
    function [12:0] settle;
        input [1:0] code;
        begin
            case (code)
                2'h0: settle = `SETTLE_CYC_0;
                2'h1: settle = `SETTLE_CYC_1;
                2'h2: settle = `SETTLE_CYC_2;
                default: settle = `SETTLE_CYC_3;
            endcase
        end
    endfunction

    // ************************************************************
    // decoded configuration outputs
    // ************************************************************
    reg applied_r;
    wire [7:0] uba = active[1];
    wire [7:0] wdg = active[2];
    wire [7:0] osc = active[3];
    wire [7:0] bor = active[4];
    wire [15:0] bsw = {active[6], active[5]};
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            applied_r <= 1'b0;
            o_config_valid <= 1'b0;
            o_readout_protect <= 1'b0;
            o_user_boot_area <= 8'h00;
            o_uba_vectors_only <= 1'b0;
            o_uba_read_protect <= 1'b0;
            o_uba_last_page <= 8'h00;
            o_indep_dog_hw_start <= 1'b0;
            o_indep_dog_halt_stop <= 1'b0;
            o_window_dog_hw_start <= 1'b0;
            o_window_dog_halt_reset <= 1'b0;
            o_fast_osc_settle_cycles <= `SETTLE_CYC_0;
            o_slow_osc_settle_cycles <= `SETTLE_CYC_0;
            o_brownout_enable <= 1'b0;
            o_brownout_threshold <= 3'h0;
            o_boot_select_word <= 16'h0000;
            o_jump_bootloader <= 1'b0;
        end else begin
            applied_r <= load_r;
            o_config_valid <= o_config_valid | applied_r;
            if (applied_r) begin
                o_readout_protect <= active[0] != `READOUT_UNLOCK_PATTERN;
                o_user_boot_area <= uba;
                o_uba_vectors_only <= uba == `UBA_VECTORS_ONLY;
                o_uba_read_protect <= uba == `UBA_TWO_PAGES;
                // last protected page N-1, only meaningful for sizes of two and up
                o_uba_last_page <= (uba >= `UBA_TWO_PAGES) ? uba - 8'h01 : 8'h00;
                o_indep_dog_hw_start <= wdg[`BIT_INDEP_DOG_HW];
                o_indep_dog_halt_stop <= wdg[`BIT_INDEP_DOG_HALT];
                o_window_dog_hw_start <= wdg[`BIT_WINDOW_DOG_HW];
                o_window_dog_halt_reset <= wdg[`BIT_WINDOW_DOG_HALT];
                o_fast_osc_settle_cycles <= settle(osc[`FAST_SETTLE_LSB +: 2]);
                o_slow_osc_settle_cycles <= settle(osc[`SLOW_SETTLE_LSB +: 2]);
                o_brownout_enable <= bor[`BIT_BROWNOUT_EN];
                o_brownout_threshold <= bor[`BROWNOUT_THR_LSB +: 3];
                o_boot_select_word <= bsw;
                // bootloader when the word is nonzero or the reset vector is blank
                o_jump_bootloader <= (bsw != 16'h0000) ||
                                     (i_reset_vector_byte == 8'hFF);
            end
        end
    end
endmodule

// [sim/option_byte_monitor.sv]
// Purpose: concurrent checks on the option byte loader ports
// Assumes: single clock domain, i_nrst asynchronous and active low
// Notes: bound to the loader from the testbench top file
`timescale 1ns/1ns
module option_byte_monitor (
    input wire i_clk,
    input wire i_nrst,
    input wire i_prog_wr,
    input wire i_prog_rd,
    input wire o_prog_ack,
    input wire i_app_wr,
    input wire i_app_rd,
    input wire o_app_ack,
    input wire o_readout_protect,
    input wire [7:0] o_user_boot_area,
    input wire o_uba_vectors_only,
    input wire o_uba_read_protect,
    input wire [7:0] o_uba_last_page,
    input wire [12:0] o_fast_osc_settle_cycles,
    input wire [12:0] o_slow_osc_settle_cycles,
    input wire o_config_valid
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // decode must land within three edges of reset release
    sequence load_done;
        !o_config_valid ##[1:3] o_config_valid;
    endsequence
    a_prog_ack_follows: assert property ((i_prog_wr || i_prog_rd) |=> o_prog_ack)
        else $error("programmer access not acknowledged");
    a_prog_ack_quiet: assert property (!(i_prog_wr || i_prog_rd) |=> !o_prog_ack)
        else $error("programmer ack without access");
    a_app_ack_follows: assert property ((i_app_wr || i_app_rd) |=> o_app_ack)
        else $error("firmware access not acknowledged");
    a_valid_after_reset: assert property ($rose(i_nrst) |-> load_done)
        else $error("configuration not loaded after reset");
    a_valid_holds: assert property (o_config_valid |=> o_config_valid)
        else $error("configuration valid dropped while running");
    a_config_frozen: assert property (o_config_valid && $past(o_config_valid) |->
        $stable({o_readout_protect, o_user_boot_area, o_fast_osc_settle_cycles}))
        else $error("configuration changed while running");
    a_vectors_only: assert property (o_uba_vectors_only == (o_user_boot_area == 8'h01))
        else $error("vectors only flag wrong");
    a_read_protect: assert property (o_uba_read_protect == (o_user_boot_area == 8'h02))
        else $error("boot area read protect flag wrong");
    a_last_page: assert property (o_uba_last_page ==
        ((o_user_boot_area >= 8'h02) ? o_user_boot_area - 8'h01 : 8'h00))
        else $error("boot area last page wrong");
    a_settle_legal: assert property (o_fast_osc_settle_cycles inside
        {13'h0001, 13'h0010, 13'h0200, 13'h1000})
        else $error("fast settle count not a legal value");
endmodule

// [sim/debug_link_programmer.sv]
// Purpose: behavioural in-circuit programmer on the debug link side
// Assumes: one-cycle strobes, ack registered one cycle later
// Notes: idle address and data lines show the inverse of the last value
`timescale 1ns/1ns
module debug_link_programmer (
    input wire i_clk,
    input wire i_ack,
    input wire [7:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [15:0] o_addr,
    output logic [7:0] o_wdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = {2'b00, 16'hFFFF, 8'hFF};
    // byte access at the option byte data-memory address
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic k);
        @(posedge i_clk);
        #1 {o_wr, o_rd, o_addr, o_wdata} = {wr, !wr, a, d};
        @(posedge i_clk);
        #1 k = i_ack;
        q = i_rdata;
        {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
    endtask
endmodule

// [sim/tb.sv]
// Purpose: self-checking bench for the option byte loader
// Assumes: 50 MHz clock, inputs driven 1 ns after the rising edge
// Notes: stored bytes survive i_nrst, so tests run in sequence
`timescale 1ns/1ns
module tb;
    logic i_clk, i_nrst, i_por_n, i_app_wr, i_app_rd;
    logic [15:0] i_app_addr;
    logic [7:0] i_app_wdata, i_reset_vector_byte;
    wire i_prog_wr, i_prog_rd, o_prog_ack, o_app_ack, o_readout_protect, o_uba_vectors_only;
    wire o_uba_read_protect, o_indep_dog_hw_start, o_indep_dog_halt_stop;
    wire o_window_dog_hw_start, o_window_dog_halt_reset, o_brownout_enable;
    wire o_jump_bootloader, o_config_valid;
    wire [15:0] i_prog_addr, o_boot_select_word;
    wire [7:0] i_prog_wdata, o_prog_rdata, o_app_rdata, o_user_boot_area, o_uba_last_page;
    wire [12:0] o_fast_osc_settle_cycles, o_slow_osc_settle_cycles;
    wire [2:0] o_brownout_threshold;
    int n_errors = 0;
    int n_checks = 0;
    option_byte_config_loader uut (.*);
    debug_link_programmer prog (.i_clk(i_clk), .i_ack(o_prog_ack), .i_rdata(o_prog_rdata),
        .o_wr(i_prog_wr), .o_rd(i_prog_rd), .o_addr(i_prog_addr), .o_wdata(i_prog_wdata));
    always #10 i_clk = ~i_clk;
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // app selects the firmware port; on reads d is the expected byte
    task automatic acc(input bit app, input bit wr, input [15:0] a, input [7:0] d);
        logic [7:0] q;
        logic k;
        if (app) begin
            @(posedge i_clk);
            #1 {i_app_wr, i_app_rd, i_app_addr, i_app_wdata} = {wr, !wr, a, d};
            @(posedge i_clk);
            #1 k = o_app_ack;
            q = o_app_rdata;
            {i_app_wr, i_app_rd, i_app_addr, i_app_wdata} = {2'b00, ~a, ~d};
        end else begin
            prog.access(wr, a, d, q, k);
        end
        chk(k, 1'b1);
        if (!wr) chk(q, d);
    endtask
    task automatic rst_pulse;
        @(posedge i_clk);
        #1 i_nrst = 1'b0;
        @(posedge i_clk);
        #1 i_nrst = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    function automatic [12:0] cyc(input [1:0] c);
        cyc = (c == 2'h0) ? 13'h0001 : (c == 2'h1) ? 13'h0010 : (c == 2'h2) ? 13'h0200 : 13'h1000;
    endfunction
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_defaults;
        acc(0, 0, 16'h4800, 8'hAA);
        for (int i = 2; i <= 12; i++) acc(0, 0, 16'h4800 + i[15:0], 8'h00);
        acc(0, 0, 16'h4900, 8'h00);
        chk(o_readout_protect, 1'b0);
        chk(o_fast_osc_settle_cycles, 13'h0001);
        chk(o_jump_bootloader, 1'b0);
        chk(o_config_valid, 1'b1);
        $display("test defaults done");
    endtask
    task automatic t_prog_all;
        acc(0, 1, 16'h4800, 8'h00);
        acc(0, 1, 16'h4802, 8'h05);
        acc(0, 1, 16'h4807, 8'h5A);
        acc(0, 1, 16'h4809, 8'h0E);
        acc(0, 1, 16'h480A, 8'h0B);
        acc(0, 1, 16'h480B, 8'h34);
        acc(0, 1, 16'h480C, 8'h12);
        acc(0, 1, 16'h4808, 8'hFF);
        acc(0, 0, 16'h4808, 8'h0F);
        acc(0, 0, 16'h4807, 8'h00);
        chk(o_readout_protect, 1'b0);
        rst_pulse();
        chk(o_readout_protect, 1'b1);
        chk(o_uba_last_page, 8'h04);
        chk(o_fast_osc_settle_cycles, 13'h0200);
        chk(o_slow_osc_settle_cycles, 13'h1000);
        chk(o_brownout_enable, 1'b1);
        chk(o_brownout_threshold, 3'h5);
        chk(o_boot_select_word, 16'h1234);
        chk(o_jump_bootloader, 1'b1);
        $display("test programmer write done");
    endtask
    task automatic t_codes;
        logic [7:0] uba [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
        logic [7:0] last [4] = '{8'h00, 8'h00, 8'h01, 8'hFE};
        for (int c = 0; c < 4; c++) begin
            acc(0, 1, 16'h4802, uba[c]);
            acc(0, 1, 16'h4809, {4'h0, c[1:0], ~c[1:0]});
            acc(0, 1, 16'h4808, 8'h01 << c);
            rst_pulse();
            chk(o_fast_osc_settle_cycles, cyc(~c[1:0]));
            chk(o_slow_osc_settle_cycles, cyc(c[1:0]));
            chk(o_uba_vectors_only, c == 1);
            chk(o_uba_last_page, last[c]);
            chk(o_uba_read_protect, c == 2);
            chk({o_window_dog_halt_reset, o_window_dog_hw_start, o_indep_dog_halt_stop,
                o_indep_dog_hw_start}, 4'h1 << c);
        end
        $display("test code tables done");
    endtask
    task automatic t_firmware;
        acc(1, 1, 16'h4800, 8'hAA);
        acc(1, 1, 16'h4802, 8'h03);
        acc(1, 1, 16'h4808, 8'h02);
        acc(1, 1, 16'h480B, 8'h00);
        acc(1, 1, 16'h480C, 8'h00);
        acc(1, 0, 16'h4800, 8'hAA);
        acc(0, 0, 16'h4800, 8'h00);
        rst_pulse();
        chk(o_readout_protect, 1'b1);
        chk(o_user_boot_area, 8'hFF);
        chk(o_indep_dog_halt_stop, 1'b1);
        chk(o_jump_bootloader, 1'b0);
        i_reset_vector_byte = 8'hFF;
        rst_pulse();
        chk(o_jump_bootloader, 1'b1);
        $display("test firmware path done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {i_clk, i_nrst, i_por_n, i_app_wr, i_app_rd} = 5'h00;
        {i_app_addr, i_app_wdata, i_reset_vector_byte} = 32'h0000_0000;
        repeat (2) @(posedge i_clk);
        #1 {i_nrst, i_por_n} = 2'b11;
        repeat (4) @(posedge i_clk);
        #1;
        t_defaults();
        t_prog_all();
        t_codes();
        t_firmware();
        complete_run();
    end
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
endmodule
bind option_byte_config_loader option_byte_monitor u_mon (.*);
